// ### src/acc_serial_ctrl.sv
// serial port, control word, calibration coefficients and ready flag of the converter
// What this block does
// - register_select low: writes load, reads return the control word.
// - control word changes only after a complete 24-bit write frame, or in its mode field when a one-shot calibration ends.
// - shift clocks after the twenty-fourth in a frame are ignored.
// - control word: mode, gain, channel, power-down, length, spare, burnout, polarity, notch.
// - mode 000 is normal; data reads return the result; reset value.
// - mode 001 self calibration, then mode clears and ready falls.
// - mode 010 zero-scale system step on channel, ready falls, back to normal.
// - mode 011 full-scale system step on channel, ready falls, back to normal.
// - mode 100 offset calibration: zero on channel, full on reference.
// - mode 101 background calibration, word rate divided by six.
// - background mode refreshes coefficient registers automatically.
// - mode 110 with select high reaches the channel zero-scale coefficient.
// - mode 111 with select high reaches the channel full-scale coefficient.
// - coefficient transfers are always 24 bits long.
// - coefficient changes only after a complete 24-bit write or a calibration or background step.
// - ready falls on a new word, rises after the word is shifted out.
// - write data sampled on rising shift clock while transmit frame low.
`timescale 1ns/100ps
module acc_serial_ctrl
    import acc_pkg::*;
(
    input wire logic ref_clk,
    input wire logic rstn,
    input wire logic shiftClock,
    input wire logic transmitFrameN,
    input wire logic receiveFrameN,
    input wire logic registerSelect,
    input wire logic serialDataIn,
    output logic serialDataOut,
    output logic serialDataOe,
    output logic conversionReadyN,
    input wire logic resultValid,
    input wire logic [23:0] conversionResult,
    input wire logic [23:0] measShorted,
    input wire logic [23:0] measReference,
    input wire logic [23:0] measInput,
    output acc_ctrl_s controlWord
);
    // pin order: shift clock, transmit frame, receive frame, select, data
    logic [4:0] pinMeta_r, pinSync_r, pinPrev_r;
    logic [23:0] inShift_r, outShift_r, result_r;
    logic [4:0] inCnt_r, outCnt_r, outLen_r;
    logic [23:0] zeroCoef_r [2];
    logic [23:0] fullCoef_r [2];
    acc_ctrl_s ctrl_r;
    logic readIsData_r, readAllowed_r, readyN_r, sdo_r, sdoOe_r, engStart_r;
    acc_mode_e engMode_r;

    wire logic sclkRise = pinSync_r[4] && !pinPrev_r[4];
    wire logic sclkFall = !pinSync_r[4] && pinPrev_r[4];
    wire logic txActive = !pinSync_r[3];
    wire logic txEnd = pinSync_r[3] && !pinPrev_r[3];
    wire logic rxActive = !pinSync_r[2];
    wire logic rxStart = !pinSync_r[2] && pinPrev_r[2];
    wire logic selHigh = pinSync_r[1];
    wire logic dataBit = pinSync_r[0];
    wire logic chan = ctrl_r.inputSelector;

    wire logic frameFull = (inCnt_r == FRAME_BITS);
    wire logic frameOk = txEnd && frameFull;
    wire logic ctrlWr = frameOk && !selHigh;
    wire logic zeroWr = frameOk && selHigh && ctrl_r.opMode == MD_ZERO_COEF;
    wire logic fullWr = frameOk && selHigh && ctrl_r.opMode == MD_FULL_COEF;
    wire logic coefSel = selHigh && (ctrl_r.opMode == MD_ZERO_COEF ||
                                     ctrl_r.opMode == MD_FULL_COEF);

    logic calDone, calBusy, bgAccept;
    acc_coef_wr_s engWr;

    // a word is ready in any mode except while calibrating; in background only on the sixth slot
    wire logic wordReady = bgAccept || (resultValid && !calBusy &&
                           ctrl_r.opMode != MD_BACKGROUND);
    // one pulse on the last shift, so a word landing later in the frame is not lost
    wire logic readDone = rxActive && readIsData_r && sclkFall && outLen_r != 5'h00 &&
                          outCnt_r == outLen_r - 5'h01;

    acc_cal_engine u_cal (
        .ref_clk(ref_clk),
        .rstn(rstn),
        .startPulse(engStart_r),
        .startMode(engMode_r),
        .backgroundOn(ctrl_r.opMode == MD_BACKGROUND),
        .resultValid(resultValid),
        .measShorted(measShorted),
        .measReference(measReference),
        .measInput(measInput),
        .calDone(calDone),
        .calBusy(calBusy),
        .bgAccept(bgAccept),
        .coefWr(engWr)
    );

    always_ff @(posedge ref_clk or negedge rstn) begin
        if (!rstn) begin
            pinMeta_r <= 5'h0E;
            pinSync_r <= 5'h0E;
            pinPrev_r <= 5'h0E;
        end else begin
            pinMeta_r <= {shiftClock, transmitFrameN, receiveFrameN, registerSelect,
                          serialDataIn};
            pinSync_r <= pinMeta_r;
            pinPrev_r <= pinSync_r;
        end
    end

    // write shifter, sampled on rising shift clock inside the frame
    always_ff @(posedge ref_clk or negedge rstn) begin
        if (!rstn) begin
            inShift_r <= 24'h000000;
            inCnt_r <= 5'h00;
        end else if (!txActive) begin
            inCnt_r <= 5'h00;
        end else if (sclkRise && !frameFull) begin
            inShift_r <= {inShift_r[22:0], dataBit};
            inCnt_r <= inCnt_r + 5'h01;
        end
    end

    always_ff @(posedge ref_clk or negedge rstn) begin
        if (!rstn) begin
            ctrl_r <= acc_ctrl_s'(CTRL_RESET_VALUE);
            engStart_r <= 1'b0;
            engMode_r <= MD_NORMAL;
        end else begin
            engStart_r <= ctrlWr;
            if (ctrlWr) begin
                ctrl_r <= acc_ctrl_s'(inShift_r);
                engMode_r <= acc_mode_e'(inShift_r[23:21]);
            end else if (calDone && accIsOneShot(ctrl_r.opMode)) begin
                ctrl_r.opMode <= MD_NORMAL;
            end
        end
    end

    always_ff @(posedge ref_clk or negedge rstn) begin
        if (!rstn) begin
            zeroCoef_r <= '{COEF_RESET_VALUE, COEF_RESET_VALUE};
            fullCoef_r <= '{COEF_RESET_VALUE, COEF_RESET_VALUE};
        end else begin
            if (zeroWr) zeroCoef_r[chan] <= inShift_r;
            else if (engWr.wrZero) zeroCoef_r[chan] <= engWr.value;
            if (fullWr) fullCoef_r[chan] <= inShift_r;
            else if (engWr.wrFull) fullCoef_r[chan] <= engWr.value;
        end
    end

    // read shifter: word chosen at frame start, advanced on falling shift clock
    wire logic [23:0] coefWord = (ctrl_r.opMode == MD_ZERO_COEF) ? zeroCoef_r[chan]
                                                                  : fullCoef_r[chan];
    wire logic [23:0] readWord = !selHigh ? ctrl_r : (coefSel ? coefWord : result_r);
    wire logic [4:0] readLen = (selHigh && !coefSel && !ctrl_r.outputWordLength)
                               ? SHORT_WORD_BITS : FRAME_BITS;

    always_ff @(posedge ref_clk or negedge rstn) begin
        if (!rstn) begin
            outShift_r <= 24'h000000;
            outCnt_r <= 5'h00;
            outLen_r <= 5'h00;
            readIsData_r <= 1'b0;
            readAllowed_r <= 1'b0;
        end else if (rxStart) begin
            outShift_r <= readWord;
            outCnt_r <= 5'h00;
            outLen_r <= readLen;
            readIsData_r <= selHigh && !coefSel;
            readAllowed_r <= !(selHigh && !coefSel && readyN_r);
        end else if (!rxActive) begin
            outCnt_r <= 5'h00;
            outLen_r <= 5'h00;
            readAllowed_r <= 1'b0;
        end else if (sclkFall && outCnt_r != outLen_r) begin
            outShift_r <= {outShift_r[22:0], 1'b0};
            outCnt_r <= outCnt_r + 5'h01;
        end
    end

    always_ff @(posedge ref_clk or negedge rstn) begin
        if (!rstn) begin
            result_r <= RESULT_RESET_VALUE;
            readyN_r <= 1'b1;
            sdo_r <= 1'b0;
            sdoOe_r <= 1'b0;
        end else begin
            if (wordReady) result_r <= conversionResult;
            // a new word or a finished calibration wins over a completed read
            if (wordReady || calDone) readyN_r <= 1'b0;
            else if (readDone && readAllowed_r) readyN_r <= 1'b1;
            sdo_r <= outShift_r[23];
            sdoOe_r <= rxActive && readAllowed_r;
        end
    end

    assign serialDataOut = sdo_r;
    assign serialDataOe = sdoOe_r;
    assign conversionReadyN = readyN_r;
    assign controlWord = ctrl_r;

    property p_ctrlShort;
        @(posedge ref_clk) disable iff (!rstn)
        (txEnd && !frameFull && !calDone) |=> $stable(ctrl_r);
    endproperty
    a_ctrlShort: assert property (p_ctrlShort) else $error("short frame changed control");

    property p_ctrlLoad;
        @(posedge ref_clk) disable iff (!rstn)
        (txEnd && frameFull && !selHigh) |=> ctrl_r == $past(inShift_r);
    endproperty
    a_ctrlLoad: assert property (p_ctrlLoad) else $error("full frame did not load control");

    property p_extraClocks;
        @(posedge ref_clk) disable iff (!rstn)
        (txActive && frameFull) |=> $stable(inShift_r) && (inCnt_r == FRAME_BITS || !txActive);
    endproperty
    a_extraClocks: assert property (p_extraClocks) else $error("clock after 24th taken");

    property p_coefShort;
        @(posedge ref_clk) disable iff (!rstn)
        (txEnd && !frameFull && !engWr.wrZero && !engWr.wrFull)
            |=> $stable(zeroCoef_r[0]) && $stable(zeroCoef_r[1]) &&
                $stable(fullCoef_r[0]) && $stable(fullCoef_r[1]);
    endproperty
    a_coefShort: assert property (p_coefShort) else $error("short frame changed coefficient");

    property p_zeroWrite;
        @(posedge ref_clk) disable iff (!rstn)
        (txEnd && frameFull && selHigh && ctrl_r.opMode == MD_ZERO_COEF && !chan)
            |=> zeroCoef_r[0] == $past(inShift_r);
    endproperty
    a_zeroWrite: assert property (p_zeroWrite) else $error("zero coefficient not written");

    property p_oneShotEnd;
        @(posedge ref_clk) disable iff (!rstn)
        (calDone && accIsOneShot(ctrl_r.opMode) && !ctrlWr)
            |=> ctrl_r.opMode == MD_NORMAL && !conversionReadyN;
    endproperty
    a_oneShotEnd: assert property (p_oneShotEnd) else $error("calibration end not signalled");

    property p_readyRise;
        @(posedge ref_clk) disable iff (!rstn)
        (readDone && readAllowed_r && !wordReady && !calDone) |=> conversionReadyN;
    endproperty
    a_readyRise: assert property (p_readyRise) else $error("ready did not rise after read");

    property p_coefLength;
        @(posedge ref_clk) disable iff (!rstn)
        (rxStart && coefSel) |=> outLen_r == FRAME_BITS ##1 serialDataOe;
    endproperty
    a_coefLength: assert property (p_coefLength) else $error("coefficient read not 24 bits");
endmodule : acc_serial_ctrl

// ### src/acc_pkg.sv
// shared constants, control word layout and mode codes of the converter control block
package acc_pkg;
    localparam int WORD_BITS = 24;
    localparam logic [4:0] FRAME_BITS = 5'h18;
    localparam logic [4:0] SHORT_WORD_BITS = 5'h10;
    localparam logic [23:0] CTRL_RESET_VALUE = 24'h000000;
    localparam logic [23:0] COEF_RESET_VALUE = 24'h000000;
    localparam logic [23:0] RESULT_RESET_VALUE = 24'h000000;
    // background calibration: one output word for every six conversion slots
    localparam logic [2:0] BG_LAST_PHASE = 3'h5;
    localparam logic [2:0] BG_ZERO_PHASE = 3'h0;
    localparam logic [2:0] BG_REF_PHASE = 3'h1;
    // one calibration step, least time
    localparam int CLK_PERIOD_NS = 50;
    localparam int CAL_STEP_NS = 2000;
    localparam logic [7:0] CAL_STEP_COUNT =
        8'((CAL_STEP_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS);

    typedef enum logic [2:0] {
        MD_NORMAL = 3'h0,
        MD_SELF_CAL = 3'h1,
        MD_SYS_ZERO = 3'h2,
        MD_SYS_FULL = 3'h3,
        MD_SYS_OFFSET = 3'h4,
        MD_BACKGROUND = 3'h5,
        MD_ZERO_COEF = 3'h6,
        MD_FULL_COEF = 3'h7
    } acc_mode_e;

    typedef struct packed {
        acc_mode_e opMode;
        logic [2:0] gainCode;
        logic inputSelector;
        logic powerDownBit;
        logic outputWordLength;
        logic dontCare;
        logic burnoutCurrentEnable;
        logic bipolarUnipolarSelect;
        logic [11:0] filterNotchCode;
    } acc_ctrl_s;

    typedef struct packed {
        logic wrZero;
        logic wrFull;
        logic [23:0] value;
    } acc_coef_wr_s;

    // one-shot calibration codes that fall back to normal mode when done
    function automatic logic accIsOneShot(input acc_mode_e m);
        accIsOneShot = (m == MD_SELF_CAL) || (m == MD_SYS_ZERO) ||
                       (m == MD_SYS_FULL) || (m == MD_SYS_OFFSET);
    endfunction : accIsOneShot
endpackage : acc_pkg

// ### src/acc_cal_engine.sv
// calibration sequencer: one-shot calibration steps and background interleaving
`timescale 1ns/100ps
module acc_cal_engine
    import acc_pkg::*;
(
    input wire logic ref_clk,
    input wire logic rstn,
    input wire logic startPulse,
    input acc_mode_e startMode,
    input wire logic backgroundOn,
    input wire logic resultValid,
    input wire logic [23:0] measShorted,
    input wire logic [23:0] measReference,
    input wire logic [23:0] measInput,
    output logic calDone,
    output logic calBusy,
    output logic bgAccept,
    output acc_coef_wr_s coefWr
);
    typedef enum logic [3:0] {
        ST_IDLE = 4'h1,
        ST_ZERO = 4'h2,
        ST_FULL = 4'h4,
        ST_DONE = 4'h8
    } acc_cal_state_e;

    acc_cal_state_e state_r, state_nxt;
    acc_mode_e mode_r;
    logic [7:0] stepCnt_r;
    logic [2:0] phase_r;

    wire logic stepEnd = (stepCnt_r == CAL_STEP_COUNT);
    wire logic needZero = (mode_r != MD_SYS_FULL);
    wire logic needFull = (mode_r != MD_SYS_ZERO);
    // zero-scale source: shorted inputs for self cal, the channel otherwise
    wire logic [23:0] zeroSrc = (mode_r == MD_SELF_CAL) ? measShorted : measInput;
    // full-scale source: the reference unless the full-scale system step
    wire logic [23:0] fullSrc = (mode_r == MD_SYS_FULL) ? measInput : measReference;
    wire logic bgSlot = backgroundOn && resultValid && (state_r == ST_IDLE);

    always_comb begin
        state_nxt = state_r;
        unique case (state_r)
            ST_IDLE: if (startPulse && accIsOneShot(startMode)) state_nxt = ST_ZERO;
            ST_ZERO: if (!needZero || stepEnd) state_nxt = needFull ? ST_FULL : ST_DONE;
            ST_FULL: if (stepEnd) state_nxt = ST_DONE;
            ST_DONE: state_nxt = ST_IDLE;
            default: state_nxt = ST_IDLE;
        endcase
    end

    always_ff @(posedge ref_clk or negedge rstn) begin
        if (!rstn) begin
            state_r <= ST_IDLE;
            mode_r <= MD_NORMAL;
            stepCnt_r <= 8'h00;
        end else begin
            state_r <= state_nxt;
            if (startPulse && state_r == ST_IDLE) mode_r <= startMode;
            stepCnt_r <= (state_nxt != state_r) ? 8'h00 : stepCnt_r + 8'h01;
        end
    end

    // background: slot 0 shorted inputs, slot 1 reference, slot 5 the word
    always_ff @(posedge ref_clk or negedge rstn) begin
        if (!rstn) begin
            phase_r <= 3'h0;
        end else if (!backgroundOn) begin
            phase_r <= 3'h0;
        end else if (bgSlot) begin
            phase_r <= (phase_r == BG_LAST_PHASE) ? 3'h0 : phase_r + 3'h1;
        end
    end

    assign calDone = (state_r == ST_DONE);
    assign calBusy = (state_r != ST_IDLE);
    assign bgAccept = bgSlot && (phase_r == BG_LAST_PHASE);
    assign coefWr.wrZero = (state_r == ST_ZERO && needZero && stepEnd) ||
                           (bgSlot && phase_r == BG_ZERO_PHASE);
    assign coefWr.wrFull = (state_r == ST_FULL && stepEnd) ||
                           (bgSlot && phase_r == BG_REF_PHASE);
    assign coefWr.value = bgSlot ? ((phase_r == BG_ZERO_PHASE) ? measShorted : measReference)
                                 : ((state_r == ST_ZERO) ? zeroSrc : fullSrc);

    property p_bgRate;
        @(posedge ref_clk) disable iff (!rstn)
        bgAccept |=> phase_r == BG_ZERO_PHASE;
    endproperty
    a_bgRate: assert property (p_bgRate) else $error("background word outside slot six");

    property p_calTakesTime;
        @(posedge ref_clk) disable iff (!rstn)
        (startPulse && state_r == ST_IDLE && accIsOneShot(startMode)) |=> !calDone [*8];
    endproperty
    a_calTakesTime: assert property (p_calTakesTime) else $error("calibration ended too soon");
endmodule : acc_cal_engine

// ### testbench/acc_host_model.sv
// host side model: framed serial writes and reads at the converter pins
`timescale 1ns/100ps
module acc_host_model (
    input wire logic ref_clk,
    input wire logic serialDataOut,
    input wire logic serialDataOe,
    output logic shiftClock,
    output logic transmitFrameN,
    output logic receiveFrameN,
    output logic registerSelect,
    output logic serialDataIn
);
    logic hostBit;
    // the data wire shows the device value while it drives, else the host value
    assign serialDataIn = serialDataOe ? serialDataOut : hostBit;
    initial begin
        shiftClock = 1'b0;
        transmitFrameN = 1'b1;
        receiveFrameN = 1'b1;
        registerSelect = 1'b0;
        hostBit = 1'b0;
    end
    task automatic ticks(input int n);
        repeat (n) @(posedge ref_clk);
        #1;
    endtask : ticks
    // nBits above 24 sends extra clocks carrying the inverse of the last bit
    task automatic writeFrame(input logic sel, input logic [23:0] value, input int nBits);
        registerSelect = sel;
        transmitFrameN = 1'b0;
        ticks(4);
        for (int i = 0; i < nBits; i++) begin
            hostBit = (i < 24) ? value[23 - i] : ~value[0];
            ticks(4);
            shiftClock = 1'b1;
            ticks(4);
            shiftClock = 1'b0;
        end
        transmitFrameN = 1'b1;
        hostBit = ~hostBit;
        ticks(6);
    endtask : writeFrame
    task automatic readFrame(input logic sel, input int nBits, output logic [23:0] value);
        value = 24'h000000;
        registerSelect = sel;
        receiveFrameN = 1'b0;
        ticks(4);
        for (int i = 0; i < nBits; i++) begin
            shiftClock = 1'b1;
            value = {value[22:0], serialDataIn};
            ticks(4);
            shiftClock = 1'b0;
            ticks(4);
        end
        receiveFrameN = 1'b1;
        // a released line shows the inverse of the last bit the device drove
        hostBit = ~value[0];
        ticks(6);
    endtask : readFrame
endmodule : acc_host_model

// ### testbench/adc_control_and_calibration_tb_top.sv
// self-checking bench of the converter control block
`timescale 1ns/100ps
module adc_control_and_calibration_tb_top;
    import acc_pkg::*;
    logic ref_clk, rstn, shiftClock, transmitFrameN, receiveFrameN, registerSelect;
    logic serialDataIn, serialDataOut, serialDataOe, conversionReadyN, resultValid;
    logic [23:0] conversionResult, measShorted, measReference, measInput, got, coef;
    logic [23:0] expZero, expFull;
    logic [2:0] mc;
    logic ch;
    acc_ctrl_s controlWord;
    int n_fail = 0;
    int n_compared = 0;
    acc_serial_ctrl u_dut (.ref_clk(ref_clk), .rstn(rstn), .shiftClock(shiftClock),
        .transmitFrameN(transmitFrameN), .receiveFrameN(receiveFrameN),
        .registerSelect(registerSelect), .serialDataIn(serialDataIn),
        .serialDataOut(serialDataOut), .serialDataOe(serialDataOe),
        .conversionReadyN(conversionReadyN), .resultValid(resultValid),
        .conversionResult(conversionResult), .measShorted(measShorted),
        .measReference(measReference), .measInput(measInput), .controlWord(controlWord));
    acc_host_model u_host (.ref_clk(ref_clk), .serialDataOut(serialDataOut),
        .serialDataOe(serialDataOe), .shiftClock(shiftClock),
        .transmitFrameN(transmitFrameN), .receiveFrameN(receiveFrameN),
        .registerSelect(registerSelect), .serialDataIn(serialDataIn));
    initial begin
        ref_clk = 1'b0;
        forever #25 ref_clk = ~ref_clk;
    end
    task automatic ticks(input int n);
        repeat (n) @(posedge ref_clk);
        #1;
    endtask : ticks
    task automatic check(input string name, input logic [23:0] seen, input logic [23:0] exp);
        n_compared++;
        if (seen !== exp) begin
            n_fail++;
            $display("MISMATCH %s expected %h seen %h", name, exp, seen);
        end
    endtask : check
    task automatic testDone(input string name);
        $display("test %s done", name);
    endtask : testDone
    task automatic pulse();
        resultValid = 1'b1;
        ticks(1);
        resultValid = 1'b0;
        ticks(3);
    endtask : pulse
    task automatic waitReady();
        int n;
        n = 0;
        while (conversionReadyN !== 1'b0 && n < 300) begin
            ticks(1);
            n++;
        end
        check("ready low", 24'(conversionReadyN), 24'h000000);
    endtask : waitReady
    task automatic end_of_test();
        $display("compared %0d mismatches %0d", n_compared, n_fail);
        if (n_fail == 0 && n_compared > 0) begin
            $display("== PASSED ==");
        end else begin
            $display("== FAILED ==");
        end
        $finish;
    endtask : end_of_test
    initial begin
        ticks(40000);
        n_fail++;
        end_of_test();
    end
    initial begin
        rstn = 1'b0;
        resultValid = 1'b0;
        conversionResult = 24'h9A7E31;
        measShorted = 24'h5A5A5A;
        measReference = 24'hC3C3C3;
        measInput = 24'h1E1E1E;
        ticks(16);
        rstn = 1'b1;
        ticks(2);
        check("ctrl reset", controlWord, CTRL_RESET_VALUE);
        check("ready reset", 24'(conversionReadyN), 24'h000001);
        testDone("reset");
        u_host.writeFrame(1'b0, 24'h0CA123, 24);
        check("ctrl write", controlWord, 24'h0CA123);
        check("gain", 24'(controlWord.gainCode), 24'h000003);
        check("length", 24'(controlWord.outputWordLength), 24'h000001);
        check("burnout", 24'(controlWord.burnoutCurrentEnable), 24'h000001);
        check("notch", 24'(controlWord.filterNotchCode), 24'h000123);
        u_host.readFrame(1'b0, 24, got);
        check("ctrl read", got, 24'h0CA123);
        check("oe idle", 24'(serialDataOe), 24'h000000);
        u_host.writeFrame(1'b0, 24'hFFFFFF, 12);
        check("ctrl short", controlWord, 24'h0CA123);
        u_host.writeFrame(1'b0, 24'h0CB456, 26);
        check("ctrl long", controlWord, 24'h0CB456);
        testDone("control word");
        for (int p = 0; p < 2; p++) begin
            for (int k = 0; k < 4; k++) begin
                mc = {2'b11, k[1]};
                ch = k[0];
                coef = {mc, ch, 20'h5A3C1};
                u_host.writeFrame(1'b0, {mc, 3'h0, ch, 17'h00000}, 24);
                if (p == 0) begin
                    u_host.writeFrame(1'b1, coef, 24);
                end else begin
                    u_host.readFrame(1'b1, 24, got);
                    check("coef", got, coef);
                end
            end
        end
        u_host.writeFrame(1'b1, 24'h000000, 20);
        u_host.readFrame(1'b1, 24, got);
        check("coef short", got, coef);
        testDone("coefficients");
        for (int m = 1; m < 5; m++) begin
            mc = 3'(m);
            measInput = {16'h1E1E, 8'(m)};
            if (m == 1) expZero = measShorted;
            else if (m != 3) expZero = measInput;
            if (m == 3) expFull = measInput;
            else if (m != 2) expFull = measReference;
            u_host.writeFrame(1'b0, {mc, 3'h0, 2'b00, 1'b1, 15'h0000}, 24);
            check("ready busy", 24'(conversionReadyN), 24'h000001);
            waitReady();
            check("mode back", 24'(controlWord.opMode), 24'(MD_NORMAL));
            u_host.readFrame(1'b1, 24, got);
            check("ready done", 24'(conversionReadyN), 24'h000001);
            u_host.writeFrame(1'b0, {MD_ZERO_COEF, 3'h0, 2'b00, 1'b1, 15'h0000}, 24);
            u_host.readFrame(1'b1, 24, got);
            check("cal zero", got, expZero);
            u_host.writeFrame(1'b0, {MD_FULL_COEF, 3'h0, 2'b00, 1'b1, 15'h0000}, 24);
            u_host.readFrame(1'b1, 24, got);
            check("cal full", got, expFull);
        end
        testDone("calibration");
        u_host.writeFrame(1'b0, 24'h008000, 24);
        u_host.readFrame(1'b1, 24, got);
        check("refused", got, {24{got[0]}});
        check("ready refused", 24'(conversionReadyN), 24'h000001);
        pulse();
        check("ready new", 24'(conversionReadyN), 24'h000000);
        u_host.readFrame(1'b1, 24, got);
        check("result", got, 24'h9A7E31);
        check("ready read", 24'(conversionReadyN), 24'h000001);
        u_host.writeFrame(1'b0, 24'h000000, 24);
        pulse();
        u_host.readFrame(1'b1, 16, got);
        check("short result", got, 24'h009A7E);
        check("ready short", 24'(conversionReadyN), 24'h000001);
        testDone("result");
        measReference = 24'h3C3C3C;
        conversionResult = 24'h4D2B17;
        u_host.writeFrame(1'b0, {MD_BACKGROUND, 3'h0, 2'b00, 1'b1, 15'h0000}, 24);
        for (int s = 0; s < 5; s++) begin
            pulse();
            check("bg slot", 24'(conversionReadyN), 24'h000001);
        end
        pulse();
        check("bg word", 24'(conversionReadyN), 24'h000000);
        u_host.readFrame(1'b1, 24, got);
        check("bg result", got, 24'h4D2B17);
        check("bg ready", 24'(conversionReadyN), 24'h000001);
        u_host.writeFrame(1'b0, {MD_ZERO_COEF, 3'h0, 2'b00, 1'b1, 15'h0000}, 24);
        u_host.readFrame(1'b1, 24, got);
        check("bg zero", got, 24'h5A5A5A);
        u_host.writeFrame(1'b0, {MD_FULL_COEF, 3'h0, 2'b00, 1'b1, 15'h0000}, 24);
        u_host.readFrame(1'b1, 24, got);
        check("bg full", got, 24'h3C3C3C);
        testDone("background");
        end_of_test();
    end
endmodule : adc_control_and_calibration_tb_top
